// ---- gdp_pkg.sv ----
// Shared constants for the dual GPIO port data block
package gdp_pkg;

    // ------------------------------------------------------------
    // Bus and data widths
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 12;         // APB byte address width
    localparam int unsigned DATA_W = 32;         // APB data width
    localparam int unsigned PORT_W = 8;          // Pins per bank

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [9:0] IDX_BANK_A_DATA = 10'h000;
    localparam logic [9:0] IDX_BANK_B_DATA = 10'h001;
    localparam logic [9:0] IDX_BANK_A_DIR  = 10'h002;
    localparam logic [9:0] IDX_BANK_B_DIR  = 10'h003;
    localparam logic [9:0] IDX_SEG_EN_A    = 10'h004;
    localparam logic [9:0] IDX_SEG_EN_B    = 10'h005;
    localparam logic [9:0] IDX_ALT_CTRL    = 10'h006;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_DATA     = 8'h00;
    localparam logic [7:0] RST_DIR      = 8'h00;
    localparam logic [7:0] RST_SEG_EN   = 8'h00;
    localparam logic [2:0] RST_ALT_CTRL = 3'h0;

    // ------------------------------------------------------------
    // Alternate control fields and bank A pin positions
    // ------------------------------------------------------------
    localparam int unsigned ALT_EXT_IRQ_EN = 0;  // External interrupt on pin 0
    localparam int unsigned ALT_NMI_EN     = 1;  // Nonmaskable input on pin 1
    localparam int unsigned ALT_CLKOUT_EN  = 2;  // Clock output on pin 3
    localparam int unsigned PIN_EXT_IRQ    = 0;
    localparam int unsigned PIN_NMI        = 1;
    localparam int unsigned PIN_CLKOUT     = 3;

    // Synchroniser depth on pin inputs
    localparam int unsigned SYNC_STAGES = 2;

endpackage

// ---- gdp_pin_mux.sv ----
// Per-pin function priority mux for one eight-pin bank
module gdp_pin_mux (
    input  wire logic [7:0] data_reg,     // Stored port data
    input  wire logic [7:0] dir_reg,      // 1 = output
    input  wire logic [7:0] seg_en,       // LCD segment enable
    input  wire logic [7:0] seg_val,      // LCD segment drive level
    input  wire logic [7:0] alt_en,       // Other alternate function active
    input  wire logic [7:0] alt_out,      // Alternate function drives pin
    input  wire logic [7:0] alt_val,      // Alternate drive level
    output logic      [7:0] pin_out_next, // Next pin drive level
    output logic      [7:0] pin_oe_n_next // Next enable, low drives
);

    // ------------------------------------------------------------
    // One priority chain per pin
    // ------------------------------------------------------------
    for (genvar i = 0; i < 8; i++) begin : g_pin
        always_comb begin
            if (seg_en[i]) begin
                // Segment driver wins over everything else
                pin_out_next[i]  = seg_val[i];
                pin_oe_n_next[i] = 1'b0;
            end else if (alt_en[i]) begin
                // Alternate function forces its own direction
                pin_out_next[i]  = alt_val[i];
                pin_oe_n_next[i] = ~alt_out[i];
            end else begin
                // Plain GPIO: drive stored bit when output
                pin_out_next[i]  = data_reg[i];
                pin_oe_n_next[i] = ~dir_reg[i];
            end
        end
    end

endmodule

// ---- gdp_port.sv ----
// Dual eight-pin GPIO port data block with APB register access
//
// Notes on behaviour
// - Output mode drives stored data bit
// - Read: data if direction 1, else pin
// - Enabled LCD segment overrides every function
// - Bank A pin 3 clock out overrides GPIO
// - Bank A pin 1 nonmaskable input overrides GPIO
// - Bank A pin 0 interrupt input overrides GPIO
// - Bank A data: 8 bits, index 0, reset 0
// - Bank B data: 8 bits, index 1, reset 0
// - Data registers accessible at any time
// - Direction 1 is output, 0 is input
// - Read settles within two cycles after direction change; code takes three after a change to input
//
// The APB interface to the registers was left to the implementer.
module gdp_port (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      pclken,
    // APB slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [gdp_pkg::ADDR_W-1:0] paddr,
    input  wire logic [gdp_pkg::DATA_W-1:0] pwdata,
    input  wire logic [3:0]                pstrb,
    output logic      [gdp_pkg::DATA_W-1:0] prdata,
    output logic                           pready,
    output logic                           pslverr,
    // Bank A pins
    input  wire logic [gdp_pkg::PORT_W-1:0] bank_a_pin_bits_in,
    output logic      [gdp_pkg::PORT_W-1:0] bank_a_pin_bits_out,
    output logic      [gdp_pkg::PORT_W-1:0] bank_a_pin_bits_oe_n,
    // Bank B pins
    input  wire logic [gdp_pkg::PORT_W-1:0] bank_b_pin_bits_in,
    output logic      [gdp_pkg::PORT_W-1:0] bank_b_pin_bits_out,
    output logic      [gdp_pkg::PORT_W-1:0] bank_b_pin_bits_oe_n,
    // LCD segment drive levels from the LCD controller
    input  wire logic [gdp_pkg::PORT_W-1:0] lcd_seg_a,
    input  wire logic [gdp_pkg::PORT_W-1:0] lcd_seg_b,
    // Clock from the wakeup timer, same clock domain
    input  wire logic                      wakeup_timer_clock_out,
    // Interrupt levels toward the core, active low like the pins
    output logic                           nonmaskable_interrupt_input_n,
    output logic                           ext_interrupt_input_n
);
    // Offsets, widths and reset values come from the shared package
    import gdp_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0] gpio_bank_a_data_reg;     // Bank A data
    logic [7:0] gpio_bank_b_data_reg;     // Bank B data
    logic [7:0] bank_a_direction_reg;     // Bank A direction
    logic [7:0] bank_b_direction_reg;     // Bank B direction
    logic [7:0] seg_en_a_reg;             // Bank A segment enables
    logic [7:0] seg_en_b_reg;             // Bank B segment enables
    logic [2:0] alt_ctrl_reg;             // Alternate function enables

    logic [7:0] sync_a_s1_reg;            // First synchroniser stage
    logic [7:0] sync_a_s2_reg;            // Settled bank A pin levels
    logic [7:0] sync_b_s1_reg;            // First synchroniser stage
    logic [7:0] sync_b_s2_reg;            // Settled bank B pin levels

    logic [DATA_W-1:0] prdata_reg;        // Registered read data
    logic [DATA_W-1:0] prdata_next;
    logic              pready_reg;        // Registered ready
    logic              pslverr_reg;       // Registered error
    logic              pslverr_next;

    logic [7:0] a_out_reg;                // Bank A pin drive
    logic [7:0] a_oe_n_reg;               // Bank A pin enable
    logic [7:0] b_out_reg;                // Bank B pin drive
    logic [7:0] b_oe_n_reg;               // Bank B pin enable
    logic [7:0] a_out_next;
    logic [7:0] a_oe_n_next;
    logic [7:0] b_out_next;
    logic [7:0] b_oe_n_next;
    logic       nmi_n_reg;                // Nonmaskable level to core
    logic       irq_n_reg;                // External interrupt to core

    logic [7:0] a_alt_en;                 // Bank A alternate active
    logic [7:0] a_alt_out;                // Bank A alternate drives
    logic [7:0] a_alt_val;                // Bank A alternate level
    logic [7:0] a_read_val;               // Bank A read value
    logic [7:0] b_read_val;               // Bank B read value

    logic [9:0] reg_idx;                  // Word index from address
    logic       addr_ok;                  // Address aligned and mapped
    logic       setup_phase;              // Setup cycle of a transfer
    logic       wr_commit;                // Write completes this edge
    logic       lane0;                    // Low byte lane written

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Registers are word spaced, so the index is the address over four.
    assign reg_idx     = paddr[ADDR_W-1:2];
    assign setup_phase = psel & ~penable;
    // Writes land only on the edge that also samples pready high.
    assign wr_commit   = psel & penable & pwrite & pready_reg;
    // Narrow registers live in byte lane 0; other lanes are ignored.
    assign lane0       = pstrb[0];

    // Map check: misaligned or out-of-range words answer with an error
    always_comb begin
        if (paddr[1:0] != 2'h0) begin
            addr_ok = 1'b0;
        end else begin
            unique case (reg_idx)
                IDX_BANK_A_DATA,
                IDX_BANK_B_DATA,
                IDX_BANK_A_DIR,
                IDX_BANK_B_DIR,
                IDX_SEG_EN_A,
                IDX_SEG_EN_B,
                IDX_ALT_CTRL:    addr_ok = 1'b1;
                default:         addr_ok = 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pin input synchronisers
    // ------------------------------------------------------------
    // Pins are asynchronous; only the second stage is ever read.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a_s1_reg <= 8'h00;
            sync_a_s2_reg <= 8'h00;
            sync_b_s1_reg <= 8'h00;
            sync_b_s2_reg <= 8'h00;
        end else if (pclken) begin
            sync_a_s1_reg <= bank_a_pin_bits_in;
            sync_a_s2_reg <= sync_a_s1_reg;
            sync_b_s1_reg <= bank_b_pin_bits_in;
            sync_b_s2_reg <= sync_b_s1_reg;
        end
    end

    // ------------------------------------------------------------
    // Data registers
    // ------------------------------------------------------------
    // No mode gating: software may read and write whenever it likes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gpio_bank_a_data_reg <= RST_DATA;
            gpio_bank_b_data_reg <= RST_DATA;
        end else if (pclken && wr_commit && lane0 && addr_ok) begin
            // Data is stored even while the pin is an input
            if (reg_idx == IDX_BANK_A_DATA) begin
                gpio_bank_a_data_reg <= pwdata[7:0];
            end
            if (reg_idx == IDX_BANK_B_DATA) begin
                gpio_bank_b_data_reg <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Direction registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank_a_direction_reg <= RST_DIR;
            bank_b_direction_reg <= RST_DIR;
        end else if (pclken && wr_commit && lane0 && addr_ok) begin
            // A set bit makes the pin an output
            if (reg_idx == IDX_BANK_A_DIR) begin
                bank_a_direction_reg <= pwdata[7:0];
            end
            if (reg_idx == IDX_BANK_B_DIR) begin
                bank_b_direction_reg <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Function select registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seg_en_a_reg <= RST_SEG_EN;
            seg_en_b_reg <= RST_SEG_EN;
            alt_ctrl_reg <= RST_ALT_CTRL;
        end else if (pclken && wr_commit && lane0 && addr_ok) begin
            // Segment enables per pin
            if (reg_idx == IDX_SEG_EN_A) begin
                seg_en_a_reg <= pwdata[7:0];
            end
            if (reg_idx == IDX_SEG_EN_B) begin
                seg_en_b_reg <= pwdata[7:0];
            end
            // Clock out and interrupt input enables
            if (reg_idx == IDX_ALT_CTRL) begin
                alt_ctrl_reg <= pwdata[2:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Bank A alternate functions
    // ------------------------------------------------------------
    // Only pins 0, 1 and 3 carry a function besides GPIO and LCD.
    // The segment check sits in the mux, so it still wins here.
    always_comb begin
        a_alt_en  = 8'h00;
        a_alt_out = 8'h00;
        a_alt_val = 8'h00;
        // Clock output: forced output with the timer clock
        a_alt_en[PIN_CLKOUT]  = alt_ctrl_reg[ALT_CLKOUT_EN];
        a_alt_out[PIN_CLKOUT] = 1'b1;
        a_alt_val[PIN_CLKOUT] = wakeup_timer_clock_out;
        // Nonmaskable interrupt: forced input
        a_alt_en[PIN_NMI]     = alt_ctrl_reg[ALT_NMI_EN];
        // External interrupt: forced input
        a_alt_en[PIN_EXT_IRQ] = alt_ctrl_reg[ALT_EXT_IRQ_EN];
    end

    // ------------------------------------------------------------
    // Pin function muxes
    // ------------------------------------------------------------
    gdp_pin_mux u_mux_a (
        .data_reg      (gpio_bank_a_data_reg),
        .dir_reg       (bank_a_direction_reg),
        .seg_en        (seg_en_a_reg),
        .seg_val       (lcd_seg_a),
        .alt_en        (a_alt_en),
        .alt_out       (a_alt_out),
        .alt_val       (a_alt_val),
        .pin_out_next  (a_out_next),
        .pin_oe_n_next (a_oe_n_next)
    );

    // Bank B has no function besides GPIO and LCD
    gdp_pin_mux u_mux_b (
        .data_reg      (gpio_bank_b_data_reg),
        .dir_reg       (bank_b_direction_reg),
        .seg_en        (seg_en_b_reg),
        .seg_val       (lcd_seg_b),
        .alt_en        (8'h00),
        .alt_out       (8'h00),
        .alt_val       (8'h00),
        .pin_out_next  (b_out_next),
        .pin_oe_n_next (b_oe_n_next)
    );

    // ------------------------------------------------------------
    // Pin drive flops
    // ------------------------------------------------------------
    // Registering the pins costs one cycle of latency but keeps
    // glitches from the decode off the pads.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_out_reg  <= 8'h00;
            a_oe_n_reg <= 8'hFF;     // All pins released at reset
            b_out_reg  <= 8'h00;
            b_oe_n_reg <= 8'hFF;
        end else if (pclken) begin
            a_out_reg  <= a_out_next;
            a_oe_n_reg <= a_oe_n_next;
            b_out_reg  <= b_out_next;
            b_oe_n_reg <= b_oe_n_next;
        end
    end

    // ------------------------------------------------------------
    // Interrupt levels to the core
    // ------------------------------------------------------------
    // A segment on the pin disconnects the interrupt path; the
    // output then rests at its inactive high level.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nmi_n_reg <= 1'b1;
            irq_n_reg <= 1'b1;
        end else if (pclken) begin
            if (alt_ctrl_reg[ALT_NMI_EN] && !seg_en_a_reg[PIN_NMI]) begin
                nmi_n_reg <= sync_a_s2_reg[PIN_NMI];
            end else begin
                nmi_n_reg <= 1'b1;
            end
            if (alt_ctrl_reg[ALT_EXT_IRQ_EN] && !seg_en_a_reg[PIN_EXT_IRQ]) begin
                irq_n_reg <= sync_a_s2_reg[PIN_EXT_IRQ];
            end else begin
                irq_n_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Read value selection
    // ------------------------------------------------------------
    // Input pins read through the synchroniser, so after a direction
    // change to input the value lags by up to three cycles: the pin drive flop plus the two synchroniser stages.
    for (genvar i = 0; i < PORT_W; i++) begin : g_read
        assign a_read_val[i] = bank_a_direction_reg[i] ?
                               gpio_bank_a_data_reg[i] :
                               sync_a_s2_reg[i];
        assign b_read_val[i] = bank_b_direction_reg[i] ?
                               gpio_bank_b_data_reg[i] :
                               sync_b_s2_reg[i];
    end

    // Read mux; upper bits read as zero
    always_comb begin
        prdata_next = '0;
        unique case (reg_idx)
            IDX_BANK_A_DATA: prdata_next[7:0] = a_read_val;
            IDX_BANK_B_DATA: prdata_next[7:0] = b_read_val;
            IDX_BANK_A_DIR:  prdata_next[7:0] = bank_a_direction_reg;
            IDX_BANK_B_DIR:  prdata_next[7:0] = bank_b_direction_reg;
            IDX_SEG_EN_A:    prdata_next[7:0] = seg_en_a_reg;
            IDX_SEG_EN_B:    prdata_next[7:0] = seg_en_b_reg;
            IDX_ALT_CTRL:    prdata_next[2:0] = alt_ctrl_reg;
            default:         prdata_next = '0;
        endcase
        if (!addr_ok) begin
            prdata_next = '0;
        end
        pslverr_next = ~addr_ok;
    end

    // ------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------
    // Read data and error are captured in the setup cycle, so the
    // first access cycle already answers: no wait states while pclken is high.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
        end else if (pclken) begin
            pready_reg <= setup_phase;
        end
    end

    // Answer data, held for the one access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= '0;
            pslverr_reg <= 1'b0;
        end else if (pclken) begin
            if (setup_phase) begin
                prdata_reg  <= pwrite ? '0 : prdata_next;
                pslverr_reg <= pslverr_next;
            end else begin
                prdata_reg  <= '0;
                pslverr_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata                        = prdata_reg;
    assign pready                        = pready_reg;
    assign pslverr                       = pslverr_reg;
    assign bank_a_pin_bits_out           = a_out_reg;
    assign bank_a_pin_bits_oe_n          = a_oe_n_reg;
    assign bank_b_pin_bits_out           = b_out_reg;
    assign bank_b_pin_bits_oe_n          = b_oe_n_reg;
    assign nonmaskable_interrupt_input_n = nmi_n_reg;
    assign ext_interrupt_input_n         = irq_n_reg;

endmodule

// ---- gdp_pin_model.sv ----
// Pin-side model of the circuit attached to one eight-pin bank
module gdp_pin_model (
    input  wire logic [7:0] pin_out,  // Level driven by the block
    input  wire logic [7:0] pin_oe_n, // Low while the block drives
    input  wire logic [7:0] ext_val,  // Level the outside circuit drives
    output logic      [7:0] pin_lvl   // Resolved wire level
);
    timeunit 1ns;
    timeprecision 1ps;
    // Outside drives only released pins, so no contention is modelled
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_lvl[i] = pin_oe_n[i] ? ext_val[i] : pin_out[i];
        end
    end
endmodule

// ---- gdp_port_sva.sv ----
// Port-level assertions for the dual GPIO port data block
module gdp_port_sva (
    input wire logic                        pclk,
    input wire logic                        presetn,
    input wire logic                        pclken,
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic [gdp_pkg::ADDR_W-1:0]  paddr,
    input wire logic [gdp_pkg::DATA_W-1:0]  prdata,
    input wire logic                        pready,
    input wire logic                        pslverr,
    input wire logic [7:0]                  bank_a_pin_bits_in,
    input wire logic [7:0]                  bank_a_pin_bits_oe_n,
    input wire logic                        nonmaskable_interrupt_input_n,
    input wire logic                        ext_interrupt_input_n
);
    timeunit 1ns;
    timeprecision 1ps;
    import gdp_pkg::*;
    logic [2:0] en_hist; // Enable history; sync latency only counts running edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_hist <= 3'h0;
        end else begin
            en_hist <= {en_hist[1:0], pclken};
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (pclken && psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_single: assert property (pready && pclken |=> !pready)
        else $error("pready held too long");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside access");
    a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("prdata upper bits set");
    a_misalign_err: assert property (pclken && psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
        else $error("misaligned access not refused");
    a_irq_released: assert property (!ext_interrupt_input_n |-> bank_a_pin_bits_oe_n[0])
        else $error("pin 0 driven while interrupt active");
    a_nmi_released: assert property (!nonmaskable_interrupt_input_n |-> bank_a_pin_bits_oe_n[1])
        else $error("pin 1 driven while nonmaskable active");
    a_irq_sync_delay: assert property (en_hist == 3'h7 && !ext_interrupt_input_n
        |-> $past(bank_a_pin_bits_in[0], 3) == 1'b0)
        else $error("interrupt level not three edges behind pin");
endmodule
bind gdp_port gdp_port_sva u_gdp_port_sva (.pclk, .presetn, .pclken, .psel, .penable, .paddr,
    .prdata, .pready, .pslverr, .bank_a_pin_bits_in, .bank_a_pin_bits_oe_n,
    .nonmaskable_interrupt_input_n, .ext_interrupt_input_n);

// ---- gdp_port_tb.sv ----
// Self-checking testbench for the dual GPIO port data block
module gdp_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import gdp_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, wclk, nmi_n, irq_n, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, v;
    logic [3:0]  pstrb;
    logic [7:0]  a_in, a_out, a_oen, b_in, b_out, b_oen, seg_a, seg_b, ext_a, ext_b, m;
    int          n_mismatch = 0, checks = 0, cyc = 0, seed = 30378;
    gdp_port u_gdp_port (.pclk, .presetn, .pclken(1'b1), .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .bank_a_pin_bits_in(a_in),
        .bank_a_pin_bits_out(a_out), .bank_a_pin_bits_oe_n(a_oen), .bank_b_pin_bits_in(b_in),
        .bank_b_pin_bits_out(b_out), .bank_b_pin_bits_oe_n(b_oen), .lcd_seg_a(seg_a),
        .lcd_seg_b(seg_b), .wakeup_timer_clock_out(wclk),
        .nonmaskable_interrupt_input_n(nmi_n), .ext_interrupt_input_n(irq_n));
    gdp_pin_model u_gdp_pin_model_a (.pin_out(a_out), .pin_oe_n(a_oen), .ext_val(ext_a),
        .pin_lvl(a_in));
    gdp_pin_model u_gdp_pin_model_b (.pin_out(b_out), .pin_oe_n(b_oen), .ext_val(ext_b),
        .pin_lvl(b_in));
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // APB transfer; holds the request until pready is sampled, then idles one cycle
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the bench watchdog ends a wait that never sees pready
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic test_done;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Hang guard; the whole run needs well under a thousand cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            test_done();
        end
    end
    initial begin
        presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; pstrb = 0;
        seg_a = 0; seg_b = 0; ext_a = 0; ext_b = 0; wclk = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1, 12'h008, 32'hFF, 4'hF);
        apb(1, 12'h00C, 32'hFF, 4'hF);
        apb(0, 12'h000, 0, 4'hF); chk("a data reset", 0, rd);
        apb(0, 12'h004, 0, 4'hF); chk("b data reset", 0, rd);
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            v = $random(seed);
            apb(1, i[0] ? 12'h004 : 12'h000, v, 4'hF);
            apb(0, i[0] ? 12'h004 : 12'h000, 0, 4'hF); chk("readback", v & 32'hFF, rd);
            chk("pin out", v[7:0], i[0] ? b_out : a_out);
            chk("pin oe_n", 0, i[0] ? b_oen : a_oen);
        end
        apb(1, 12'h004, ~v, 4'hE);
        apb(0, 12'h004, 0, 4'hF); chk("strobe ignore", v & 32'hFF, rd);
        $display("output test done");
        ext_b <= 8'($random(seed));
        apb(1, 12'h00C, 0, 4'hF);
        repeat (3) @(posedge pclk);
        apb(0, 12'h004, 0, 4'hF); chk("b input read", {24'h0, ext_b}, rd);
        chk("b released", 8'hFF, b_oen);
        $display("input test done");
        m = 8'($random(seed));
        seg_a <= 8'($random(seed));
        seg_b <= 8'($random(seed));
        apb(1, 12'h018, 32'h4, 4'hF);
        apb(1, 12'h010, m | 8'h08, 4'hF);
        apb(1, 12'h014, 32'hFF, 4'hF);
        // Pin flops load one edge after the commit, so let that edge pass
        @(posedge pclk);
        chk("seg out", seg_a & (m | 8'h08), a_out & (m | 8'h08));
        chk("seg oe_n", 0, a_oen & (m | 8'h08));
        chk("seg b", {seg_b, 8'h00}, {b_out, b_oen});
        apb(1, 12'h010, 0, 4'hF);
        apb(1, 12'h014, 0, 4'hF);
        apb(1, 12'h008, 0, 4'hF);
        for (int k = 0; k < 2; k++) begin
            wclk <= ~wclk;
            repeat (2) @(posedge pclk);
            chk("clock out", {wclk, 1'b0}, {a_out[3], a_oen[3]});
        end
        $display("priority test done");
        ext_a <= 8'h00;
        apb(1, 12'h008, 32'hFF, 4'hF);
        apb(1, 12'h018, 32'h3, 4'hF);
        repeat (4) @(posedge pclk);
        chk("irq pins released", 2'h3, a_oen[1:0]);
        chk("irq low", 2'h0, {nmi_n, irq_n});
        ext_a <= 8'h03;
        repeat (4) @(posedge pclk);
        chk("irq high", 2'h3, {nmi_n, irq_n});
        $display("interrupt test done");
        apb(0, 12'h040, 0, 4'hF); chk("unmapped err", 1, err);
        apb(0, 12'h002, 0, 4'hF); chk("misaligned err", 1, err);
        chk("err rdata", 0, rd);
        $display("error test done");
        test_done();
    end
endmodule
